/* hw/ifepr_pkg.sv */
// package: register map, field layout, reset values for the flag/enable/priority block
package ifepr_pkg;
	localparam int NSRC = 32;
	localparam int NPRI = NSRC / 4;
	// byte addresses of the map
	localparam logic [7:0] ADDR_RELOAD    = 8'h00;
	localparam logic [7:0] ADDR_FLAGS     = 8'h04;
	localparam logic [7:0] ADDR_ENABLES   = 8'h08;
	localparam logic [7:0] ADDR_THRESHOLD = 8'h0C;
	localparam logic [7:0] ADDR_IRQSTAT   = 8'h10;
	localparam logic [7:0] ADDR_IRQMASK   = 8'h14;
	localparam logic [7:0] ADDR_TIMER     = 8'h18;
	localparam logic [7:0] ADDR_PRI_BASE  = 8'h20;
	localparam logic [7:0] ADDR_PRI_LAST  = 8'h3C;
	// priority lane layout
	localparam int LANE_W   = 8;
	localparam int PRI_LSB  = 2;
	localparam int PRI_W    = 3;
	localparam int SUB_LSB  = 0;
	localparam int SUB_W    = 2;
	localparam logic [7:0] LANE_MASK = 8'h1F;
	// status bits of the interrupt register
	localparam int ST_TRIG  = 0;
	localparam int ST_EXP   = 1;
	localparam int ST_W     = 2;
	// reset values and bus response codes
	localparam logic [31:0] RST_WORD = 32'h00000000;
	localparam logic [2:0]  RST_THR  = 3'h0;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;
endpackage

/* hw/ifepr_lane.sv */
// one priority lane: field masking and request qualification
`timescale 1ns/1ps
`default_nettype none
module ifepr_lane (
	input  wire logic [7:0] laneIn,
	input  wire logic       flag,
	input  wire logic       enable,
	input  wire logic [2:0] threshold,
	output logic [7:0]      laneOut,
	output logic            active,
	output logic            trigger,
	output logic [2:0]      prio,
	output logic [1:0]      subprio
);
	// upper lane bits are masked off by LANE_MASK on the way out, so they always read zero
	always_comb begin
		laneOut = laneIn & ifepr_pkg::LANE_MASK;
		prio    = laneIn[ifepr_pkg::PRI_LSB +: ifepr_pkg::PRI_W];
		subprio = laneIn[ifepr_pkg::SUB_LSB +: ifepr_pkg::SUB_W];
		active  = flag && enable && (prio != 3'h0);
		trigger = active && (threshold != 3'h0) && (prio <= threshold);
	end
endmodule
`default_nettype wire

/* hw/ifepr_top.sv */
// flag, enable and priority registers with proximity timer, AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module ifepr_top (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [31:0] srcEvent,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             cpuReq,
	output logic [2:0]       cpuPrio,
	output logic [1:0]       cpuSubprio,
	output logic [4:0]       cpuSrc,
	output logic             irq
);
	typedef struct packed {
		logic [31:0]    reload;
		logic [31:0]    flags;
		logic [31:0]    enables;
		logic [255:0]   prio;
		logic [2:0]     threshold;
		logic [31:0]    timer;
		logic [1:0]     irqStat;
		logic [1:0]     irqMask;
		logic           awHeld;
		logic [7:0]     awAddr;
		logic           wHeld;
		logic [31:0]    wData;
		logic [3:0]     wStrb;
		logic           bValid;
		logic [1:0]     bResp;
		logic           rValid;
		logic [31:0]    rData;
		logic [1:0]     rResp;
		logic           req;
		logic [2:0]     reqPrio;
		logic [1:0]     reqSub;
		logic [4:0]     reqSrc;
		logic           irqOut;
	} ifepr_state_t;

	ifepr_state_t st_ff;
	ifepr_state_t nxt_st;

	logic [255:0] prioRead;
	logic [31:0]  active;
	logic [31:0]  trigger;
	logic [95:0]  prioBus;
	logic [63:0]  subBus;

	// one lane per source, qualifies its request and threshold hit
	genvar g;
	generate
		for (g = 0; g < ifepr_pkg::NSRC; g++) begin : gLane
			ifepr_lane uLane (
				.laneIn    (st_ff.prio[g*8 +: 8]),
				.flag      (st_ff.flags[g]),
				.enable    (st_ff.enables[g]),
				.threshold (st_ff.threshold),
				.laneOut   (prioRead[g*8 +: 8]),
				.active    (active[g]),
				.trigger   (trigger[g]),
				.prio      (prioBus[g*3 +: 3]),
				.subprio   (subBus[g*2 +: 2])
			);
		end
	endgenerate

	function automatic logic [31:0] applyStrb(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = dat[b*8 +: 8];
			end
		end
		return r;
	endfunction

	logic        doWrite;
	logic        doRead;
	logic        wrHit;
	logic [7:0]  rdA;
	logic [31:0] wMerged;
	logic [2:0]  bestP;
	logic [1:0]  bestS;
	logic [4:0]  bestI;
	logic        bestV;
	logic        timerFire;

	// next state: bus, flags, timer, arbitration
	always_comb begin
		nxt_st  = st_ff;
		doWrite = 1'b0;
		doRead  = 1'b0;
		wrHit   = 1'b0;
		rdA     = s_axi_araddr;
		wMerged = 32'h00000000;
		bestP   = 3'h0;
		bestS   = 2'h0;
		bestI   = 5'h00;
		bestV   = 1'b0;
		timerFire = 1'b0;

		// capture address and data independently, in either order
		if (s_axi_awvalid && !st_ff.awHeld) begin
			nxt_st.awHeld = 1'b1;
			nxt_st.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_ff.wHeld) begin
			nxt_st.wHeld = 1'b1;
			nxt_st.wData = s_axi_wdata;
			nxt_st.wStrb = s_axi_wstrb;
		end
		if (st_ff.bValid && s_axi_bready) begin
			nxt_st.bValid = 1'b0;
		end
		if (st_ff.awHeld && st_ff.wHeld && !st_ff.bValid) begin
			doWrite = 1'b1;
			nxt_st.awHeld = 1'b0;
			nxt_st.wHeld  = 1'b0;
			nxt_st.bValid = 1'b1;
			nxt_st.bResp  = ifepr_pkg::RESP_OK;
		end

		// hardware events set flags first; a software write below replaces the stored flags but keeps new events
		nxt_st.flags = st_ff.flags | srcEvent;

		if (doWrite) begin
			wMerged = st_ff.wData;
			case (st_ff.awAddr)
				ifepr_pkg::ADDR_RELOAD: begin
					nxt_st.reload = applyStrb(st_ff.reload, wMerged,
						st_ff.wStrb);
				end
				ifepr_pkg::ADDR_FLAGS: begin
					// a new event in the same cycle still sets its flag
					nxt_st.flags = applyStrb(st_ff.flags, wMerged,
						st_ff.wStrb) | srcEvent;
				end
				ifepr_pkg::ADDR_ENABLES: begin
					nxt_st.enables = applyStrb(st_ff.enables, wMerged,
						st_ff.wStrb);
				end
				ifepr_pkg::ADDR_THRESHOLD: begin
					if (st_ff.wStrb[0]) begin
						nxt_st.threshold = wMerged[2:0];
					end
				end
				ifepr_pkg::ADDR_IRQSTAT: begin
					if (st_ff.wStrb[0]) begin
						nxt_st.irqStat = st_ff.irqStat & ~wMerged[1:0];
					end
				end
				ifepr_pkg::ADDR_IRQMASK: begin
					if (st_ff.wStrb[0]) begin
						nxt_st.irqMask = wMerged[1:0];
					end
				end
				default: begin
					wrHit = (st_ff.awAddr >= ifepr_pkg::ADDR_PRI_BASE) &&
						(st_ff.awAddr <= ifepr_pkg::ADDR_PRI_LAST) &&
						(st_ff.awAddr[1:0] == 2'h0);
					if (wrHit) begin
						// lane masking keeps unused bits at zero
						nxt_st.prio[st_ff.awAddr[4:2]*32 +: 32] =
							applyStrb(st_ff.prio[st_ff.awAddr[4:2]*32 +: 32],
							wMerged & 32'h1F1F1F1F, st_ff.wStrb);
					end else begin
						nxt_st.bResp = ifepr_pkg::RESP_ERR;
					end
				end
			endcase
		end

		// proximity timer: reload on a qualifying event when at zero, count down while nonzero, else hold at zero
		if (|trigger && (st_ff.timer == 32'h00000000)) begin
			nxt_st.timer = st_ff.reload;
		end else if (st_ff.timer != 32'h00000000) begin
			nxt_st.timer = st_ff.timer - 32'h00000001;
			timerFire = (st_ff.timer == 32'h00000001);
		end
		if (st_ff.threshold == 3'h0) begin
			nxt_st.timer = 32'h00000000;
			timerFire = 1'b0;
		end

		// interrupt status: set wins over a simultaneous clear
		nxt_st.irqStat[ifepr_pkg::ST_TRIG] = nxt_st.irqStat[ifepr_pkg::ST_TRIG]
			| (|trigger && (st_ff.timer == 32'h00000000));
		nxt_st.irqStat[ifepr_pkg::ST_EXP] = nxt_st.irqStat[ifepr_pkg::ST_EXP]
			| timerFire;
		nxt_st.irqOut = |(nxt_st.irqStat & nxt_st.irqMask);

		// highest priority, then subpriority, then lowest index wins
		for (int i = 0; i < ifepr_pkg::NSRC; i++) begin
			if (active[i] && (!bestV || prioBus[i*3 +: 3] > bestP ||
				(prioBus[i*3 +: 3] == bestP && subBus[i*2 +: 2] > bestS))) begin
				bestV = 1'b1;
				bestP = prioBus[i*3 +: 3];
				bestS = subBus[i*2 +: 2];
				bestI = 5'(i);
			end
		end
		nxt_st.req     = bestV;
		nxt_st.reqPrio = bestP;
		nxt_st.reqSub  = bestS;
		nxt_st.reqSrc  = bestI;

		// read channel: one read outstanding at a time
		if (st_ff.rValid && s_axi_rready) begin
			nxt_st.rValid = 1'b0;
		end
		if (s_axi_arvalid && !st_ff.rValid) begin
			doRead = 1'b1;
			nxt_st.rValid = 1'b1;
			nxt_st.rResp  = ifepr_pkg::RESP_OK;
			case (rdA)
				ifepr_pkg::ADDR_RELOAD:    nxt_st.rData = st_ff.reload;
				ifepr_pkg::ADDR_FLAGS:     nxt_st.rData = st_ff.flags;
				ifepr_pkg::ADDR_ENABLES:   nxt_st.rData = st_ff.enables;
				ifepr_pkg::ADDR_THRESHOLD: nxt_st.rData = {29'h0, st_ff.threshold};
				ifepr_pkg::ADDR_IRQSTAT:   nxt_st.rData = {30'h0, st_ff.irqStat};
				ifepr_pkg::ADDR_IRQMASK:   nxt_st.rData = {30'h0, st_ff.irqMask};
				ifepr_pkg::ADDR_TIMER:     nxt_st.rData = st_ff.timer;
				default: begin
					if ((rdA >= ifepr_pkg::ADDR_PRI_BASE) &&
						(rdA <= ifepr_pkg::ADDR_PRI_LAST) &&
						(rdA[1:0] == 2'h0)) begin
						nxt_st.rData = prioRead[rdA[4:2]*32 +: 32];
					end else begin
						nxt_st.rData = 32'h00000000;
						nxt_st.rResp = ifepr_pkg::RESP_ERR;
					end
				end
			endcase
		end
	end

	// single register stage for all state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from flops
	assign s_axi_awready = !st_ff.awHeld;
	assign s_axi_wready  = !st_ff.wHeld;
	assign s_axi_bvalid  = st_ff.bValid;
	assign s_axi_bresp   = st_ff.bResp;
	assign s_axi_arready = !st_ff.rValid;
	assign s_axi_rvalid  = st_ff.rValid;
	assign s_axi_rdata   = st_ff.rData;
	assign s_axi_rresp   = st_ff.rResp;
	assign cpuReq        = st_ff.req;
	assign cpuPrio       = st_ff.reqPrio;
	assign cpuSubprio    = st_ff.reqSub;
	assign cpuSrc        = st_ff.reqSrc;
	assign irq           = st_ff.irqOut;

	// checks
	property p_flag_set;
		@(posedge clk_sys) disable iff (rst)
		srcEvent[0] |=> st_ff.flags[0];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set");

	property p_flag_sticky;
		@(posedge clk_sys) disable iff (rst)
		(st_ff.flags[0] && !doWrite) |=> st_ff.flags[0];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

	property p_req_qual;
		@(posedge clk_sys) disable iff (rst)
		cpuReq |-> $past(|(st_ff.flags & st_ff.enables));
	endproperty
	a_req_qual: assert property (p_req_qual) else $error("bad request");

	property p_req_prio;
		@(posedge clk_sys) disable iff (rst)
		cpuReq |-> cpuPrio != 3'h0;
	endproperty
	a_req_prio: assert property (p_req_prio) else $error("zero prio");

	// looks at the stored lanes, so a write path that keeps spare bits fails
	property p_lane_zero;
		@(posedge clk_sys) disable iff (rst)
		(st_ff.prio & ~{8{32'h1F1F1F1F}}) == 256'h0;
	endproperty
	a_lane_zero: assert property (p_lane_zero) else $error("lane bits");

	property p_timer_off;
		@(posedge clk_sys) disable iff (rst)
		(st_ff.threshold == 3'h0) |=> st_ff.timer == 32'h00000000;
	endproperty
	a_timer_off: assert property (p_timer_off) else $error("timer on");

	property p_reload;
		@(posedge clk_sys) disable iff (rst)
		(|trigger && st_ff.timer == 32'h0 && st_ff.threshold != 3'h0)
			|=> st_ff.timer == $past(st_ff.reload);
	endproperty
	a_reload: assert property (p_reload) else $error("no reload");

	property p_enable_block;
		@(posedge clk_sys) disable iff (rst)
		(st_ff.enables == 32'h0) |=> !cpuReq;
	endproperty
	a_enable_block: assert property (p_enable_block) else $error("disabled src");

	// the presented source must have been a qualified one
	property p_req_src;
		@(posedge clk_sys) disable iff (rst)
		cpuReq |-> (($past(active) >> cpuSrc) & 32'h00000001)
			!= 32'h00000000;
	endproperty
	a_req_src: assert property (p_req_src) else $error("bad winner");

	property p_read_answer;
		@(posedge clk_sys) disable iff (rst)
		doRead |=> s_axi_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("no rvalid");

	sequence s_wr_both;
		st_ff.awHeld && st_ff.wHeld && !st_ff.bValid;
	endsequence
	property p_bresp;
		@(posedge clk_sys) disable iff (rst)
		s_wr_both |=> s_axi_bvalid;
	endproperty
	a_bresp: assert property (p_bresp) else $error("no bvalid");
endmodule
`default_nettype wire

/* verification/ifepr_core_model.sv */
// core-side model: takes the request that is presented to the processor
`timescale 1ns/1ps
`default_nettype none
module ifepr_core_model (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       cpuReq,
	input  wire logic [2:0] cpuPrio,
	input  wire logic [1:0] cpuSubprio,
	input  wire logic [4:0] cpuSrc,
	output logic [9:0]      taken
);
	// the core accepts whatever is offered; last taken stays for inspection
	always_ff @(posedge clk_sys) begin
		if (rst)
			taken <= 10'h000;
		else if (cpuReq)
			taken <= {cpuPrio, cpuSubprio, cpuSrc};
	end
endmodule
`default_nettype wire

/* verification/interrupt_flag_enable_priority_regs_bench.sv */
// self-checking bench for the flag, enable and priority register block
`timescale 1ns/1ps
`default_nettype none
module interrupt_flag_enable_priority_regs_bench;
	logic        clk_sys, rst, awValid, wValid, arValid, awReady, wReady;
	logic        arReady, bValid, rValid, cpuReq, irq;
	logic [31:0] srcEvent, wData, rData, rBus, d, e;
	logic [7:0]  awAddr, arAddr;
	logic [3:0]  wStrb;
	logic [1:0]  bResp, rResp, rRespSeen, cpuSub, bRespSeen;
	logic [2:0]  cpuPrio;
	logic [4:0]  cpuSrc, s;
	logic [9:0]  taken;
	integer      seed, err_total, n_compared, p;

	ifepr_top ifepr_top_inst (.clk_sys(clk_sys), .rst(rst),
		.srcEvent(srcEvent), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(1'b1), .s_axi_araddr(arAddr),
		.s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rBus), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(1'b1), .cpuReq(cpuReq), .cpuPrio(cpuPrio),
		.cpuSubprio(cpuSub), .cpuSrc(cpuSrc), .irq(irq));

	ifepr_core_model ifepr_core_model_inst (.clk_sys(clk_sys), .rst(rst),
		.cpuReq(cpuReq), .cpuPrio(cpuPrio), .cpuSubprio(cpuSub),
		.cpuSrc(cpuSrc), .taken(taken));

	// 40 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic cmp(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// expected readback of a priority word: two fields per lane survive
	function automatic logic [31:0] prio_exp(input logic [31:0] w);
		return w & 32'h1F1F1F1F;
	endfunction

	// expected word after a write with byte strobes
	function automatic logic [31:0] strb_exp(input logic [31:0] old,
		input logic [31:0] v, input logic [3:0] m);
		logic [31:0] mk;
		mk = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
		return (old & ~mk) | (v & mk);
	endfunction

	// ready and response are both read at the sampling edge itself;
	// a valid is only lowered while still up, so a following call can
	// raise it again in the same step without a second assignment
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] m = 4'hF);
		awAddr <= a;
		wData <= v;
		wStrb <= m;
		awValid <= 1'b1;
		wValid <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (awValid && awReady) awValid <= 1'b0;
			if (wValid && wReady) wValid <= 1'b0;
		end while (!bValid);
		bRespSeen = bResp;
	endtask

	task automatic rd(input logic [7:0] a);
		arAddr <= a;
		arValid <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (arValid && arReady) arValid <= 1'b0;
		end while (!rValid);
		rData = rBus;
		rRespSeen = rResp;
	endtask

	// registered outputs lag a write by up to two edges
	task automatic settle;
		repeat (3) @(posedge clk_sys);
	endtask

	task automatic pulse(input logic [31:0] v);
		srcEvent <= v;
		@(posedge clk_sys);
		srcEvent <= 32'h00000000;
	endtask

	task final_report;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// cut a hang short well past the expected run length
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		final_report;
	end

	initial begin
		seed = 76;
		err_total = 0;
		n_compared = 0;
		rst <= 1'b1;
		srcEvent <= 32'h00000000;
		awValid <= 1'b0;
		wValid <= 1'b0;
		arValid <= 1'b0;
		awAddr <= 8'h00;
		arAddr <= 8'h00;
		wData <= 32'h00000000;
		wStrb <= 4'hF;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		// whole map reads clear after reset
		for (p = 0; p < 16; p++) begin
			rd(8'(4 * p));
			cmp("reset", 32'h00000000, rData);
		end
		d = $random(seed);
		wr(ifepr_pkg::ADDR_RELOAD, d);
		rd(ifepr_pkg::ADDR_RELOAD);
		cmp("reload", d, rData);
		cmp("bresp", 32'(ifepr_pkg::RESP_OK), 32'(bRespSeen));
		// only the strobed bytes of a partial write change
		e = $random(seed);
		wr(ifepr_pkg::ADDR_RELOAD, e, 4'h5);
		rd(ifepr_pkg::ADDR_RELOAD);
		cmp("strobe", strb_exp(d, e, 4'h5), rData);
		// random words: only the two fields of each lane survive
		for (p = 0; p < 8; p++) begin
			d = $random(seed);
			wr(ifepr_pkg::ADDR_PRI_BASE + 8'(4 * p), d);
			rd(ifepr_pkg::ADDR_PRI_BASE + 8'(4 * p));
			cmp("prio", prio_exp(d), rData);
		end
		rd(8'hFC);
		cmp("resp", 32'(ifepr_pkg::RESP_ERR), 32'(rRespSeen));
		wr(8'hFC, d);
		cmp("bresp", 32'(ifepr_pkg::RESP_ERR), 32'(bRespSeen));
		// a one-cycle event leaves a sticky flag behind
		d = $random(seed);
		pulse(d);
		rd(ifepr_pkg::ADDR_FLAGS);
		cmp("flags", d, rData);
		wr(ifepr_pkg::ADDR_FLAGS, 32'h00000000);
		rd(ifepr_pkg::ADDR_FLAGS);
		cmp("flags", 32'h00000000, rData);
		// every priority code once, blocked until enabled
		for (p = 0; p < 8; p++) begin
			s = 5'($random(seed));
			wr(ifepr_pkg::ADDR_PRI_BASE + {1'b0, s[4:2], 2'b00},
				32'({3'(p), 2'(p)}) << (8 * s[1:0]));
			pulse(32'h00000001 << s);
			settle;
			cmp("req off", 32'h00000000, 32'(cpuReq));
			wr(ifepr_pkg::ADDR_ENABLES, 32'h00000001 << s);
			settle;
			cmp("req", 32'(p != 0), 32'(cpuReq));
			if (p != 0)
				cmp("taken", 32'({3'(p), 2'(p), s}), 32'(taken));
			wr(ifepr_pkg::ADDR_FLAGS, 32'h00000000);
			wr(ifepr_pkg::ADDR_ENABLES, 32'h00000000);
		end
		// source 0 at priority 2 starts the timer only at threshold 2 or more
		wr(ifepr_pkg::ADDR_PRI_BASE, 32'h00000008);
		wr(ifepr_pkg::ADDR_ENABLES, 32'h00000001);
		pulse(32'h00000001);
		wr(ifepr_pkg::ADDR_RELOAD, 32'h00000003);
		wr(ifepr_pkg::ADDR_IRQMASK, 32'h00000001);
		wr(ifepr_pkg::ADDR_THRESHOLD, 32'h00000002);
		settle;
		rd(ifepr_pkg::ADDR_IRQSTAT);
		cmp("started", 32'h00000001, rData & 32'h00000001);
		cmp("irq", 32'h00000001, 32'(irq));
		wr(ifepr_pkg::ADDR_THRESHOLD, 32'h00000001);
		settle;
		// the countdown from reload has run out at least once by now
		rd(ifepr_pkg::ADDR_IRQSTAT);
		cmp("expired", 32'h00000002, rData & 32'h00000002);
		wr(ifepr_pkg::ADDR_IRQSTAT, 32'h00000003);
		settle;
		rd(ifepr_pkg::ADDR_IRQSTAT);
		cmp("started", 32'h00000000, rData & 32'h00000001);
		cmp("irq", 32'h00000000, 32'(irq));
		wr(ifepr_pkg::ADDR_THRESHOLD, 32'h00000000);
		settle;
		rd(ifepr_pkg::ADDR_TIMER);
		cmp("timer", 32'h00000000, rData);
		// second reset in mid-run clears what the tests left behind
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rd(ifepr_pkg::ADDR_RELOAD);
		cmp("reset", 32'h00000000, rData);
		rd(ifepr_pkg::ADDR_ENABLES);
		cmp("reset", 32'h00000000, rData);
		rd(ifepr_pkg::ADDR_PRI_BASE);
		cmp("reset", 32'h00000000, rData);
		cmp("req", 32'h00000000, 32'(cpuReq));
		cmp("irq", 32'h00000000, 32'(irq));
		final_report;
	end
endmodule
`default_nettype wire
